// ===== design/ayb_fifo.sv
// Result word FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module ayb_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Streams
  ayb_stream_if.snk in_s,
  ayb_stream_if.src out_s
);
  // DEPTH must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic out_valid_r;
  logic [WIDTH-1:0] out_data_r;
  logic push;
  logic pop;

  assign in_s.ready = (count_r != FULL_CNT);
  assign push = in_s.valid && in_s.ready;
  assign pop = (count_r != '0) && (!out_valid_r || out_s.ready);
  assign out_s.valid = out_valid_r;
  assign out_s.data = out_data_r;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_s.data;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_r <= '0;
    end else begin
      unique case ({push, pop})
        2'b10: count_r <= count_r + 1'b1;
        2'b01: count_r <= count_r - 1'b1;
        default: count_r <= count_r;
      endcase
    end
  end

  // Output register refills whenever it empties or is consumed
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else if (pop) begin
      out_valid_r <= 1'b1;
      out_data_r <= mem[rd_ptr_r];
    end else if (out_s.ready) begin
      out_valid_r <= 1'b0;
    end
  end
endmodule // ayb_fifo
`default_nettype wire

// ===== design/ayb_port.sv
// Processor-side Y bus transfer logic for the accelerator and port devices
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE_01 - Accelerator snoops opcode bytes during decode
// RULE_02 - Misc drives working register; field2=2 strobes operand
// RULE_03 - Accelerator takes operands unstalled except polynomial_evaluation
// RULE_04 - Operand send repeats while ready sync low
// RULE_05 - Accelerator captures word, drops sync that microcycle
// RULE_06 - Data path 5 move reads bus into store
// RULE_07 - Result completes only with read and sync
// RULE_08 - Select flop set by field1=8, cleared by 9
// RULE_09 - Field2=3 traps accelerator to bus microaddress
// RULE_10 - Field2=4 then move reads micro-PC, no loop
// RULE_11 - Bit 18 makes port command, bits 17:10
// RULE_12 - Port command strobes and drives working register
// RULE_13 - Port device answers first read, no sync
// RULE_14 - Longword port read waits one cycle after command
// RULE_15 - Automatic mode reads need no repeated commands
// RULE_16 - Port traffic requires accelerator deselected first
// RULE_17 - Port devices decode address in command high bits
// RULE_18 - Unaddressed devices leave Y bus undriven
module ayb_port #(
  parameter int UCYCLE_DIV = ayb_pkg::UCYCLE_DIV,
  parameter int FIFO_DEPTH = ayb_pkg::RESULT_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Microinstruction from the sequencer, held until done
  input wire logic ui_valid,
  input wire logic ui_is_move,
  input wire logic [ayb_pkg::CSR_W-1:0] ui_csr,
  input wire logic [2:0] ui_data_path_field,
  input wire logic [ayb_pkg::LS_AW-1:0] ui_d_addr,
  input wire logic ui_longword,
  input wire logic [ayb_pkg::YBUS_W-1:0] wreg_data,
  output logic ui_done,
  output logic ui_busy,
  output logic port_while_accel,
  // Y bus pin
  input wire logic [ayb_pkg::YBUS_W-1:0] ybus_in,
  output logic [ayb_pkg::YBUS_W-1:0] ybus_out,
  output logic ybus_oe_n,
  // Accelerator and port control pins
  input wire logic accel_ready_sync,
  output logic operand_available_strobe,
  output logic read_port_strobe,
  output logic accel_trap,
  output logic read_micro_pc,
  output logic accel_select_ff,
  output logic port_instruction_strobe,
  output logic [7:0] port_cmd_byte,
  // Local store write stream
  output logic ls_wr_valid,
  input wire logic ls_wr_ready,
  output logic [ayb_pkg::LS_AW-1:0] ls_wr_addr,
  output logic [ayb_pkg::YBUS_W-1:0] ls_wr_data
);
  localparam int YW = ayb_pkg::YBUS_W;
  localparam int AW = ayb_pkg::LS_AW;
  localparam int DW = $clog2(UCYCLE_DIV);
  localparam logic [DW-1:0] DIV_LAST = DW'(UCYCLE_DIV - 1);
  localparam int GW = $clog2(ayb_pkg::LONG_READ_GAP + 1);
  localparam logic [GW-1:0] GAP_CNT = GW'(ayb_pkg::LONG_READ_GAP);

  // Microcycle enable
  logic [DW-1:0] div_r;
  logic tick_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == DIV_LAST);
      div_r <= (div_r == DIV_LAST) ? '0 : div_r + 1'b1;
    end
  end

  // Pin synchronisers; a level counts once stages two and three agree
  logic [2:0] sync_sh_r;
  logic accel_ready_sync_q_r;
  logic [YW-1:0] yb1_r;
  logic [YW-1:0] yb2_r;
  logic [YW-1:0] yb3_r;
  logic [YW-1:0] ybus_q_r;
  logic [YW-1:0] ybus_agree;

  // Agreed bus level, usable at the very edge that settles it, so a read
  // sampled at the fourth edge after the strobe takes the new word
  assign ybus_agree = (~(yb2_r ^ yb3_r) & yb3_r) |
                      ((yb2_r ^ yb3_r) & ybus_q_r);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_sh_r <= 3'h0;
      accel_ready_sync_q_r <= 1'b0;
    end else begin
      sync_sh_r <= {sync_sh_r[1:0], accel_ready_sync};
      if (sync_sh_r[1] == sync_sh_r[2]) begin
        accel_ready_sync_q_r <= sync_sh_r[2];
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      yb1_r <= ayb_pkg::YBUS_RST;
      yb2_r <= ayb_pkg::YBUS_RST;
      yb3_r <= ayb_pkg::YBUS_RST;
      ybus_q_r <= ayb_pkg::YBUS_RST;
    end else begin
      yb1_r <= ybus_in;
      yb2_r <= yb1_r;
      yb3_r <= yb2_r;
      ybus_q_r <= ybus_agree;
    end
  end

  // Decode of the held microinstruction
  logic is_port_cmd;
  logic is_misc;
  logic is_port_read_move;
  logic [3:0] f1;
  logic [3:0] f2;

  assign f1 = ui_csr[ayb_pkg::F1_HI:ayb_pkg::F1_LO];
  assign f2 = ui_csr[ayb_pkg::F2_HI:ayb_pkg::F2_LO];
  assign is_port_cmd = !ui_is_move && ui_csr[ayb_pkg::CSR_PORT_BIT]; // RULE_11
  assign is_misc = !ui_is_move && !ui_csr[ayb_pkg::CSR_PORT_BIT];
  assign is_port_read_move = ui_is_move &&
                             (ui_data_path_field == ayb_pkg::MDP_PORT_READ);

  // Result buffer between the Y bus and local store
  ayb_stream_if #(.WIDTH(AW + YW)) res_in ();
  ayb_stream_if #(.WIDTH(AW + YW)) res_out ();

  ayb_fifo #(
    .WIDTH(AW + YW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .in_s(res_in.snk),
    .out_s(res_out.src)
  );

  assign res_out.ready = ls_wr_ready;
  assign ls_wr_valid = res_out.valid;
  assign ls_wr_addr = res_out.data[AW+YW-1:YW];
  assign ls_wr_data = res_out.data[YW-1:0];

  // Sequencer state
  ayb_pkg::ayb_state_e state_r;
  logic upc_pending_r;
  logic last_port_cmd_r;
  logic [GW-1:0] gap_r;
  logic complete;
  logic launch;
  logic need_gap;

  // Completion at the end of the microcycle being executed
  always_comb begin
    complete = 1'b1;
    if (is_port_read_move) begin
      if (accel_select_ff) begin
        // Micro-PC read answers on the first strobe
        complete = (accel_ready_sync_q_r || upc_pending_r) && res_in.ready; // RULE_07 RULE_10
      end else begin
        complete = res_in.ready; // RULE_13 RULE_15
      end
    end else if (is_misc && f2 == ayb_pkg::F2_OPERAND) begin
      complete = accel_ready_sync_q_r; // RULE_04
    end
  end

  assign need_gap = is_port_read_move && !accel_select_ff && ui_longword &&
                    last_port_cmd_r; // RULE_14
  assign launch = tick_r && ui_valid &&
                  ((state_r == ayb_pkg::AYB_IDLE && !need_gap) ||
                   (state_r == ayb_pkg::AYB_HOLD && gap_r == '0));

  // Capture the read word with its store address
  assign res_in.valid = tick_r && state_r == ayb_pkg::AYB_EXEC &&
                        is_port_read_move && complete; // RULE_06
  assign res_in.data = {ui_d_addr, ybus_agree};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ayb_pkg::AYB_IDLE;
      gap_r <= '0;
    end else if (tick_r) begin
      unique case (state_r)
        ayb_pkg::AYB_IDLE: begin
          if (ui_valid && need_gap) begin
            state_r <= ayb_pkg::AYB_HOLD;
            gap_r <= GAP_CNT - 1'b1;
          end else if (ui_valid) begin
            state_r <= ayb_pkg::AYB_EXEC;
          end
        end
        ayb_pkg::AYB_HOLD: begin
          if (gap_r == '0) begin
            state_r <= ayb_pkg::AYB_EXEC;
          end else begin
            gap_r <= gap_r - 1'b1;
          end
        end
        ayb_pkg::AYB_EXEC: begin
          // Incomplete transfers repeat with outputs held
          if (complete) begin
            state_r <= ayb_pkg::AYB_IDLE;
          end
        end
        default: state_r <= ayb_pkg::AYB_IDLE;
      endcase
    end
  end

  logic finish;
  assign finish = tick_r && state_r == ayb_pkg::AYB_EXEC && complete;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ui_done <= 1'b0;
      ui_busy <= 1'b0;
    end else begin
      ui_done <= finish;
      if (launch || (tick_r && ui_valid && state_r == ayb_pkg::AYB_IDLE)) begin
        ui_busy <= 1'b1;
      end else if (finish) begin
        ui_busy <= 1'b0;
      end
    end
  end

  // History of the previous microinstruction
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      upc_pending_r <= 1'b0;
      last_port_cmd_r <= 1'b0;
    end else if (finish) begin
      upc_pending_r <= is_misc && f2 == ayb_pkg::F2_READ_UPC; // RULE_10
      last_port_cmd_r <= is_port_cmd; // RULE_14
    end
  end

  // Accelerator select flop
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      accel_select_ff <= 1'b0;
    end else if (launch && is_misc) begin
      if (f1 == ayb_pkg::F1_SEL_ACCEL) begin
        accel_select_ff <= 1'b1; // RULE_08
      end else if (f1 == ayb_pkg::F1_DESEL_ACCEL) begin
        accel_select_ff <= 1'b0; // RULE_08 RULE_16
      end
    end
  end

  // Y bus drive: misc and port drive, moves release for the partner
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ybus_out <= ayb_pkg::YBUS_RST;
      ybus_oe_n <= 1'b1;
    end else if (launch) begin
      ybus_out <= wreg_data; // RULE_02 RULE_09 RULE_12
      ybus_oe_n <= ui_is_move; // RULE_06
    end else if (finish) begin
      ybus_oe_n <= 1'b1;
    end
  end

  // Strobes stand for the whole execution, repeats included
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      operand_available_strobe <= 1'b0;
      accel_trap <= 1'b0;
      read_micro_pc <= 1'b0;
      read_port_strobe <= 1'b0;
    end else if (launch) begin
      operand_available_strobe <= is_misc && f2 == ayb_pkg::F2_OPERAND; // RULE_02
      accel_trap <= is_misc && f2 == ayb_pkg::F2_TRAP; // RULE_09
      read_micro_pc <= is_misc && f2 == ayb_pkg::F2_READ_UPC; // RULE_10
      read_port_strobe <= is_port_read_move; // RULE_06
    end else if (finish) begin
      operand_available_strobe <= 1'b0;
      accel_trap <= 1'b0;
      read_micro_pc <= 1'b0;
      read_port_strobe <= 1'b0;
    end
  end

  // Port command; refused while the accelerator owns the bus
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      port_instruction_strobe <= 1'b0;
      port_cmd_byte <= ayb_pkg::CMD_RST;
      port_while_accel <= 1'b0;
    end else begin
      port_while_accel <= launch && accel_select_ff && is_port_cmd; // RULE_16
      if (launch && is_port_cmd && !accel_select_ff) begin
        port_instruction_strobe <= 1'b1; // RULE_12
        port_cmd_byte <= ui_csr[ayb_pkg::CMD_HI:ayb_pkg::CMD_LO]; // RULE_11
      end else if (finish) begin
        port_instruction_strobe <= 1'b0;
      end
    end
  end
endmodule // ayb_port
`default_nettype wire

// ===== inc/ayb_pkg.sv
// Constants shared by the accelerator and port Y bus transfer logic
package ayb_pkg;
  // Microcycle divider and synchroniser depth
  localparam int UCYCLE_DIV = 4;
  localparam int SYNC_STAGES = 3;
  // Microinstruction control word layout
  localparam int CSR_W = 19;
  localparam int CSR_PORT_BIT = 18;
  localparam int CMD_HI = 17;
  localparam int CMD_LO = 10;
  localparam int F1_HI = 17;
  localparam int F1_LO = 14;
  localparam int F2_HI = 13;
  localparam int F2_LO = 10;
  // Function field codes
  localparam logic [3:0] F1_SEL_ACCEL = 4'h8;
  localparam logic [3:0] F1_DESEL_ACCEL = 4'h9;
  localparam logic [3:0] F2_OPERAND = 4'h2;
  localparam logic [3:0] F2_TRAP = 4'h3;
  localparam logic [3:0] F2_READ_UPC = 4'h4;
  localparam logic [2:0] MDP_PORT_READ = 3'h5;
  // Microcycles a longword port read waits after its command
  localparam int LONG_READ_GAP = 1;
  // Data widths and buffer depth
  localparam int YBUS_W = 32;
  localparam int LS_AW = 4;
  localparam int RESULT_FIFO_DEPTH = 32;
  // Reset values
  localparam logic [YBUS_W-1:0] YBUS_RST = 32'h0000_0000;
  localparam logic [7:0] CMD_RST = 8'h00;
  // Sequencer states
  typedef enum logic [1:0] {
    AYB_IDLE = 2'b00,
    AYB_EXEC = 2'b01,
    AYB_HOLD = 2'b10
  } ayb_state_e;
endpackage

// ===== inc/ayb_stream_if.sv
// Valid/ready word stream between the transfer logic and its buffer
`timescale 1ns/1ps
`default_nettype none
interface ayb_stream_if #(
  parameter int WIDTH = 36
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== sim/ayb_partner.sv
// Behavioural accelerator and port device on the far side of the Y bus
`timescale 1ns/1ps
`default_nettype none
module ayb_partner #(
  parameter logic [3:0] PORT_ADDR = 4'h5
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Pins from the block
  input wire logic [31:0] ybus_out,
  input wire logic ybus_oe_n,
  input wire logic operand_available_strobe,
  input wire logic read_port_strobe,
  input wire logic accel_trap,
  input wire logic read_micro_pc,
  input wire logic accel_select_ff,
  input wire logic port_instruction_strobe,
  input wire logic [7:0] port_cmd_byte,
  // Ready delay after each transfer
  input wire logic [3:0] dly,
  // Pins to the block
  output logic [31:0] ybus_in,
  output logic accel_ready_sync
);
  logic [31:0] res_r, upc_r, pw_r, last_r, drv;
  logic [7:0] cmd_r, idx_r;
  logic [3:0] cnt_r;
  logic pend_r, rp_q, op_q, acc_rd, prt_rd;
  assign acc_rd = read_port_strobe & accel_select_ff;
  // Released bus shows a changing pattern, not the last word
  assign prt_rd = read_port_strobe & ~accel_select_ff
    & (cmd_r[7:4] == PORT_ADDR);
  assign drv = acc_rd ? (pend_r ? upc_r : res_r)
    : pw_r + {24'h0, idx_r};
  assign ybus_in = !ybus_oe_n ? ybus_out
    : (acc_rd | prt_rd) ? drv : ~last_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {res_r, upc_r, pw_r, last_r, cmd_r, idx_r} <= '0;
      {cnt_r, pend_r, rp_q, op_q, accel_ready_sync} <= '0;
    end else begin
      rp_q <= read_port_strobe;
      op_q <= operand_available_strobe;
      last_r <= ybus_in;
      if (operand_available_strobe & accel_ready_sync)
        res_r <= ~ybus_out;
      if (accel_ready_sync && ((op_q && !operand_available_strobe)
          || (rp_q && !read_port_strobe && accel_select_ff))) begin
        accel_ready_sync <= 1'b0;
        cnt_r <= 4'h0;
        pend_r <= 1'b0;
      end else if (!accel_ready_sync) begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r >= dly || (pend_r && read_port_strobe))
          accel_ready_sync <= 1'b1;
      end
      if (read_micro_pc) pend_r <= 1'b1;
      if (accel_trap) upc_r <= ybus_out;
      if (port_instruction_strobe) begin
        cmd_r <= port_cmd_byte;
        pw_r <= ybus_out;
        idx_r <= 8'h00;
      end
      if (rp_q && !read_port_strobe && prt_rd == 1'b0 && cmd_r[0]
          && !accel_select_ff) idx_r <= idx_r + 8'h01;
    end
  end
endmodule // ayb_partner
`default_nettype wire

// ===== sim/ayb_port_properties.sv
// Port-level checks for the Y bus transfer block
`timescale 1ns/1ps
`default_nettype none
module ayb_port_chk (
  // Clock, reset and inputs
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [ayb_pkg::CSR_W-1:0] ui_csr,
  input wire logic accel_ready_sync,
  // Outputs
  input wire logic ui_done,
  input wire logic ybus_oe_n,
  input wire logic operand_available_strobe,
  input wire logic read_port_strobe,
  input wire logic accel_trap,
  input wire logic accel_select_ff,
  input wire logic port_instruction_strobe,
  input wire logic [7:0] port_cmd_byte
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  op_drive_a: assert property (
    operand_available_strobe |-> !ybus_oe_n)
    else $error("operand strobe without bus drive");
  read_release_a: assert property (
    read_port_strobe |-> ybus_oe_n)
    else $error("bus driven during read");
  sel_set_a: assert property (
    $rose(accel_select_ff) |-> $past(ui_csr[17:14]) == 4'h8)
    else $error("select set without code 8");
  sel_clr_a: assert property (
    $fell(accel_select_ff) |-> $past(ui_csr[17:14]) == 4'h9)
    else $error("select cleared without code 9");
  port_sel_a: assert property (
    port_instruction_strobe |-> !accel_select_ff)
    else $error("port command with accelerator selected");
  port_cmd_a: assert property (
    $rose(port_instruction_strobe)
      |-> port_cmd_byte == ui_csr[17:10] && !ybus_oe_n)
    else $error("port command byte or drive wrong");
  trap_drive_a: assert property (
    accel_trap |-> !ybus_oe_n)
    else $error("trap without microaddress on bus");
  op_end_a: assert property (
    $fell(operand_available_strobe) |-> ui_done)
    else $error("operand strobe dropped early");
  op_wait_a: assert property (
    (!accel_ready_sync)[*8] |-> !$fell(operand_available_strobe))
    else $error("operand sent without ready");
endmodule // ayb_port_chk
bind ayb_port ayb_port_chk i_ayb_port_chk (.mclk, .nrst, .ui_csr,
  .accel_ready_sync, .ui_done, .ybus_oe_n, .operand_available_strobe,
  .read_port_strobe, .accel_trap, .accel_select_ff,
  .port_instruction_strobe, .port_cmd_byte);
`default_nettype wire

// ===== sim/tb_ayb_port.sv
// Self-checking bench for the Y bus transfer block
`timescale 1ns/1ps
`default_nettype none
module tb_ayb_port;
  logic mclk, nrst, ui_valid, ui_is_move, ui_longword, ls_rdy, pwa_seen;
  logic [ayb_pkg::CSR_W-1:0] ui_csr;
  logic [3:0] ui_d_addr, dly, lsa;
  logic [31:0] wreg_data, ybus_in, ybus_out, lsd;
  logic ui_done, ui_busy, pwa, oe_n, sync, ops, rps, trap, rupc, sel, pis;
  logic lsv;
  logic [7:0] pcb;
  logic [2:0] data_path_field;
  logic [35:0] q[$];
  int error_cnt, checks_done;
  ayb_port i_ayb_port (.mclk, .nrst, .ui_valid, .ui_is_move, .ui_csr,
    .ui_data_path_field(data_path_field), .ui_d_addr, .ui_longword, .wreg_data,
    .ui_done, .ui_busy, .port_while_accel(pwa), .ybus_in, .ybus_out,
    .ybus_oe_n(oe_n), .accel_ready_sync(sync),
    .operand_available_strobe(ops), .read_port_strobe(rps),
    .accel_trap(trap), .read_micro_pc(rupc), .accel_select_ff(sel),
    .port_instruction_strobe(pis), .port_cmd_byte(pcb),
    .ls_wr_valid(lsv), .ls_wr_ready(ls_rdy), .ls_wr_addr(lsa),
    .ls_wr_data(lsd));
  ayb_partner i_ayb_partner (.mclk, .nrst, .ybus_out, .ybus_oe_n(oe_n),
    .operand_available_strobe(ops), .read_port_strobe(rps),
    .accel_trap(trap), .read_micro_pc(rupc), .accel_select_ff(sel),
    .port_instruction_strobe(pis), .port_cmd_byte(pcb), .dly,
    .ybus_in, .accel_ready_sync(sync));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (lsv && ls_rdy) q.push_back({lsa, lsd});
    if (pwa === 1'b1) pwa_seen <= 1'b1;
  end
  task automatic end_of_test;
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [35:0] g, input logic [35:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  function automatic logic [18:0] misc(input logic [3:0] f1, f2);
    return {1'b0, f1, f2, 10'h000};
  endfunction
  function automatic logic [18:0] port(input logic [7:0] c);
    return {1'b1, c, 10'h000};
  endfunction
  // Holds the microinstruction until done, bounded wait
  task automatic ex(input logic mv, input logic [18:0] c,
                    input logic [31:0] w);
    int n;
    @(posedge mclk);
    #1;
    ui_is_move = mv;
    ui_csr = c;
    wreg_data = w;
    ui_valid = 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (ui_done !== 1'b1 && n < 300);
    if (n >= 300) cmp('x, 36'h0);
    ui_valid = 1'b0;
  endtask
  task automatic rd(input logic [35:0] e);
    int n;
    n = 0;
    while (q.size() == 0 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    cmp(q.size() > 0 ? q.pop_front() : 'x, e);
  endtask
  task automatic t_accel;
    ex(1'b0, misc(4'h8, 4'h0), 32'h0);
    cmp({35'h0, sel}, 36'h1);
    // Slow partner: the second operand has to wait for ready sync
    dly = 4'hC;
    ex(1'b0, misc(4'h0, 4'h2), 32'h1234_5678);
    ex(1'b0, misc(4'h0, 4'h2), 32'hA5C3_0F96);
    ui_d_addr = 4'h3;
    ex(1'b1, 19'h0, 32'h0);
    rd({4'h3, 32'h5A3C_F069});
  endtask
  task automatic t_upc;
    ex(1'b0, misc(4'h0, 4'h3), 32'h0000_01F4);
    ex(1'b0, misc(4'h0, 4'h4), 32'h0);
    ui_d_addr = 4'h7;
    ex(1'b1, 19'h0, 32'h0);
    rd({4'h7, 32'h0000_01F4});
    // Move with another data path code must not store a word
    data_path_field = 3'h0;
    ex(1'b1, 19'h0, 32'h0);
    repeat (8) @(posedge mclk);
    #1;
    cmp(36'(q.size()), 36'h0);
    data_path_field = 3'h5;
  endtask
  task automatic t_refuse;
    pwa_seen = 1'b0;
    ex(1'b0, port(8'h52), 32'h0);
    @(posedge mclk);
    #1;
    cmp({35'h0, pwa_seen}, 36'h1);
  endtask
  task automatic t_port;
    time t0;
    ex(1'b0, misc(4'h9, 4'h0), 32'h0);
    cmp({35'h0, sel}, 36'h0);
    ex(1'b0, port(8'h50), 32'hC0DE_0042);
    cmp({28'h0, pcb}, 36'h50);
    ui_longword = 1'b1;
    ui_d_addr = 4'h9;
    t0 = $time;
    ex(1'b1, 19'h0, 32'h0);
    // One extra microcycle of wait: twelve clocks instead of eight
    cmp(36'($time - t0), 36'h78);
    rd({4'h9, 32'hC0DE_0042});
    ui_longword = 1'b0;
  endtask
  // Buffer fills with the sink stalled, then drains in order
  task automatic t_fifo;
    int i;
    ls_rdy = 1'b0;
    ui_d_addr = 4'hA;
    ex(1'b0, port(8'h51), 32'h0000_1000);
    fork
      for (i = 0; i < 34; i++) ex(1'b1, 19'h0, 32'h0);
      begin
        repeat (450) @(posedge mclk);
        #1;
        cmp({35'h0, ui_busy}, 36'h1);
        ls_rdy = 1'b1;
      end
    join
    for (i = 0; i < 34; i++) rd({4'hA, 32'h0000_1000 + i});
  endtask
  initial begin
    {nrst, ui_valid, ui_is_move, ui_longword, pwa_seen} = '0;
    {ui_csr, ui_d_addr, dly, wreg_data} = '0;
    ls_rdy = 1'b1;
    data_path_field = 3'h5;
    repeat (16) @(posedge mclk);
    #1;
    nrst = 1'b1;
    t_accel();
    t_upc();
    t_refuse();
    t_port();
    t_fifo();
    end_of_test();
  end
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
endmodule // tb_ayb_port
`default_nettype wire
